/* File: rtl/ltscr_top.sv */
// Logic tile status and control registers, datapath routing and I/O port routing.
`timescale 1ns/1ps
`default_nettype none
module ltscr_top
  import ltscr_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Routing matrix
  input wire logic [RT_W-1:0] rt_in,
  output logic [CTRL_W-1:0] ctrl_rt,
  output logic [1:0] pta_clk_en,
  output logic [NUM_REQ-1:0] req_out,
  // Datapath and chaining
  input wire logic [DP_IO-1:0] dp_in,
  output logic [DP_IO-1:0] dp_out,
  input wire logic chain_cin_i,
  input wire logic chain_sin_i,
  input wire logic chain_eq_i,
  output logic chain_cout,
  output logic chain_sout,
  output logic chain_eq,
  // Port routing
  input wire logic [PORT_W-1:0] pin_out_rt,
  input wire logic [NUM_OE-1:0] oe_rt,
  input wire logic [NUM_DRV-1:0] drv_rt,
  output logic [PORT_W-1:0] pin_in_rt,
  output logic [NUM_DRV-1:0] pin_drv,
  // Pins
  input wire logic [PORT_W-1:0] pin_i,
  output logic [PORT_W-1:0] pin_o,
  output logic [PORT_W-1:0] pin_oe_n
);
  logic ack_r;
  logic [DAT_W-1:0] rdat_r;
  logic [DAT_W-1:0] rdat_c;
  logic [DAT_W-1:0] wmask;
  logic [ADR_W-1:0] adr_w;
  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic cfg_hit;
  logic [CTRL_W-1:0] ctrl_r;
  logic [31:0] stsel_r;
  logic [STAT_W-1:0] stken_r;
  logic [23:0] cmap_r;
  logic [15:0] clkcfg_r;
  logic [17:0] dpsel_r;
  logic chain_en_r;
  logic [15:0] reqsel_r;
  logic [17:0] iocfg_r;
  logic [7:0] a0_r;
  logic [7:0] d0_r;
  logic carry_r;
  logic shift_r;
  logic [STAT_W-1:0] sticky_r;
  logic [STAT_W-1:0] stat_live;
  logic [STAT_W-1:0] stat_val;
  logic [STAT_W-1:0] stk_set;
  logic stat_rd;
  logic [NUM_SUB-1:0] sub_en;
  logic [ROUTE_W-1:0] route_vec;
  logic req_pick0;
  logic [CFG_W-1:0] cw;
  ltscr_op_t op;
  ltscr_sh_t shm;
  ltscr_cin_t cin_sel;
  ltscr_sin_t sin_sel;
  logic cin;
  logic sin;
  logic [8:0] sum9;
  logic [7:0] sh_res;
  logic alu_cout;
  logic alu_sout;
  logic [7:0] cond;
  logic [CTRL_W-1:0] ctrl_rt_r;
  logic [1:0] pta_en_r;
  logic [NUM_REQ-1:0] req_r;
  logic [DP_IO-1:0] dp_out_r;
  logic chain_cout_r;
  logic chain_sout_r;
  logic chain_eq_r;
  logic [PORT_W-1:0] s1_r;
  logic [PORT_W-1:0] s2_r;
  logic [PORT_W-1:0] s3_r;
  logic [PORT_W-1:0] pin_in_r;
  logic [PORT_W-1:0] pipe_r;
  logic [PORT_W-1:0] pin_o_r;
  logic [PORT_W-1:0] oe_c;
  logic [PORT_W-1:0] pin_oe_n_r;
  logic [NUM_DRV-1:0] drv_r;
  ltscr_oe_t oe_mode;

  ltscr_cfg_if #(.AW(CFG_AW), .DW(CFG_W)) cfg ();

  ltscr_cfg_ram #(.AW(CFG_AW), .DW(CFG_W)) u_cfg_ram (
    .clk(clk),
    .reset(reset),
    .mp(cfg.mem)
  );

  // A request is taken once; ack blocks a second take of the same strobe.
  assign adr_w = {wb_adr_i[ADR_W-1:2], 2'b00};
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_en = bus_req & wb_we_i;
  assign rd_en = bus_req & ~wb_we_i;
  assign cfg_hit = adr_w[7:5] == OFS_CFGRAM[7:5];
  assign stat_rd = rd_en & (adr_w == OFS_STAT);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // The memory takes whole words only, so a write needs all four lanes.
  assign cfg.we = wr_en & cfg_hit & (&wb_sel_i);
  assign cfg.waddr = adr_w[4:2];
  assign cfg.wdata = wb_dat_i[CFG_W-1:0];
  assign cfg.raddr = dp_in[CFG_AW-1:0];
  assign cw = cfg.rdata;

  always_comb begin
    case (adr_w)
      OFS_CTRL: rdat_c = 32'(ctrl_r);
      OFS_STAT: rdat_c = 32'(stat_val);
      OFS_STSEL: rdat_c = stsel_r;
      OFS_STKEN: rdat_c = 32'(stken_r);
      OFS_CMAP: rdat_c = 32'(cmap_r);
      OFS_CLKCFG: rdat_c = 32'(clkcfg_r);
      OFS_DPSEL: rdat_c = 32'(dpsel_r);
      OFS_DPCTL: rdat_c = 32'(chain_en_r);
      OFS_ACC: rdat_c = 32'(a0_r);
      OFS_DATA: rdat_c = 32'(d0_r);
      OFS_REQSEL: rdat_c = 32'(reqsel_r);
      OFS_IOCFG: rdat_c = 32'(iocfg_r);
      default: rdat_c = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req;
      if (rd_en) begin
        rdat_r <= rdat_c;
      end
    end
  end

  // Status reads are read-only; writes to that offset are acknowledged and dropped.
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= RST_CTRL;
      stsel_r <= RST_STSEL;
      stken_r <= 8'h00;
      cmap_r <= RST_CMAP;
      clkcfg_r <= 16'h0000;
      dpsel_r <= 18'h00000;
      chain_en_r <= 1'b0;
      reqsel_r <= 16'h0000;
      iocfg_r <= RST_IOCFG;
    end else if (wr_en) begin
      if (adr_w == OFS_CTRL) begin
        ctrl_r <= (ctrl_r & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
      end
      if (adr_w == OFS_STSEL) begin
        stsel_r <= (stsel_r & ~wmask) | (wb_dat_i & wmask);
      end
      if (adr_w == OFS_STKEN) begin
        stken_r <= (stken_r & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
      end
      if (adr_w == OFS_CMAP) begin
        cmap_r <= (cmap_r & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
      end
      if (adr_w == OFS_CLKCFG) begin
        clkcfg_r <= (clkcfg_r & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      if (adr_w == OFS_DPSEL) begin
        dpsel_r <= (dpsel_r & ~wmask[17:0]) | (wb_dat_i[17:0] & wmask[17:0]);
      end
      if (adr_w == OFS_DPCTL && wb_sel_i[0]) begin
        chain_en_r <= wb_dat_i[0];
      end
      if (adr_w == OFS_REQSEL) begin
        reqsel_r <= (reqsel_r & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      if (adr_w == OFS_IOCFG) begin
        iocfg_r <= (iocfg_r & ~wmask[17:0]) | (wb_dat_i[17:0] & wmask[17:0]);
      end
    end
  end

  // Clock enables: a gated subcomponent follows the control bit it selects.
  always_comb begin
    for (int i = 0; i < NUM_SUB; i++) begin
      sub_en[i] = ~clkcfg_r[4*i + CLK_GATE_BIT] | ctrl_r[clkcfg_r[4*i +: 3]];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pta_en_r <= 2'b11;
      ctrl_rt_r <= 8'h00;
    end else begin
      pta_en_r <= sub_en[1:0];
      for (int k = 0; k < CTRL_W; k++) begin
        ctrl_rt_r[k] <= ctrl_r[cmap_r[3*k +: 3]];
      end
    end
  end

  // Status unit.
  assign route_vec = {rt_in, dp_out_r, pin_in_r[1:0]};

  always_comb begin
    for (int i = 0; i < STAT_W; i++) begin
      stat_live[i] = route_vec[stsel_r[4*i +: 4]];
    end
  end

  assign stk_set = stat_live & stken_r & {STAT_W{sub_en[SUB_SC]}};
  assign stat_val = (stat_live & ~stken_r) | (sticky_r & stken_r);

  // The set term comes last so a fresh event survives the clearing read.
  always_ff @(posedge clk) begin
    if (reset) begin
      sticky_r <= 8'h00;
    end else begin
      sticky_r <= (sticky_r & ~{STAT_W{stat_rd}}) | stk_set;
    end
  end

  // Datapath.
  assign op = ltscr_op_t'(cw[CW_OP_LSB +: 3]);
  assign shm = ltscr_sh_t'(cw[CW_SH_LSB +: 2]);
  assign cin_sel = ltscr_cin_t'(cw[CW_CIN_LSB +: 2]);
  assign sin_sel = ltscr_sin_t'(cw[CW_SIN_LSB +: 2]);

  always_comb begin
    unique case (cin_sel)
      CIN_ZERO: cin = 1'b0;
      CIN_ONE: cin = 1'b1;
      CIN_CHAIN: cin = chain_en_r ? chain_cin_i : dp_in[4];
      CIN_REG: cin = carry_r;
    endcase
    unique case (sin_sel)
      SIN_ROUTE: sin = dp_in[3];
      SIN_CHAIN: sin = chain_en_r & chain_sin_i;
      SIN_REG: sin = shift_r;
      SIN_ZERO: sin = 1'b0;
    endcase
  end

  always_comb begin
    unique case (op)
      OP_INC: sum9 = {1'b0, a0_r} + 9'h001;
      OP_DEC: sum9 = {1'b0, a0_r} + 9'h0FF;
      OP_ADD: sum9 = {1'b0, a0_r} + {1'b0, d0_r} + {8'h00, cin};
      OP_SUB: sum9 = {1'b0, a0_r} + {1'b0, ~d0_r} + {8'h00, cin};
      OP_AND: sum9 = {1'b0, a0_r & d0_r};
      OP_OR: sum9 = {1'b0, a0_r | d0_r};
      OP_XOR: sum9 = {1'b0, a0_r ^ d0_r};
      OP_PASS: sum9 = {1'b0, a0_r};
    endcase
    alu_cout = sum9[8];
    unique case (shm)
      SH_NONE: begin
        sh_res = sum9[7:0];
        alu_sout = 1'b0;
      end
      SH_LEFT: begin
        sh_res = {sum9[6:0], sin};
        alu_sout = sum9[7];
      end
      SH_RIGHT: begin
        sh_res = {sin, sum9[7:1]};
        alu_sout = sum9[0];
      end
      SH_SWAP: begin
        sh_res = {sum9[3:0], sum9[7:4]};
        alu_sout = 1'b0;
      end
    endcase
  end

  assign cond = {shift_r, carry_r, alu_sout, alu_cout, sh_res == 8'hFF, sh_res == 8'h00,
    a0_r < d0_r, (a0_r == d0_r) & (~chain_en_r | chain_eq_i)};

  // Registered carry and shift-out let one 8-bit ALU build 16-bit work over two cycles.
  always_ff @(posedge clk) begin
    if (reset) begin
      carry_r <= 1'b0;
      shift_r <= 1'b0;
    end else if (sub_en[SUB_DP]) begin
      carry_r <= alu_cout;
      shift_r <= alu_sout;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      a0_r <= 8'h00;
    end else if (wr_en && adr_w == OFS_ACC && wb_sel_i[0]) begin
      a0_r <= wb_dat_i[7:0];
    end else if (sub_en[SUB_DP] && cw[CW_WR_BIT] && !dp_in[5]) begin
      a0_r <= sh_res;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      d0_r <= 8'h00;
    end else if (wr_en && adr_w == OFS_DATA && wb_sel_i[0]) begin
      d0_r <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dp_out_r <= 6'h00;
      chain_cout_r <= 1'b0;
      chain_sout_r <= 1'b0;
      chain_eq_r <= 1'b0;
    end else begin
      for (int k = 0; k < DP_IO; k++) begin
        dp_out_r[k] <= cond[dpsel_r[3*k +: 3]];
      end
      chain_cout_r <= chain_en_r & alu_cout;
      chain_sout_r <= chain_en_r & alu_sout;
      chain_eq_r <= chain_en_r & cond[0];
    end
  end

  // Request multiplexer.
  assign req_pick0 = route_vec[reqsel_r[3:0]];

  always_ff @(posedge clk) begin
    if (reset) begin
      req_r <= 4'h0;
    end else begin
      for (int k = 0; k < NUM_REQ; k++) begin
        req_r[k] <= route_vec[reqsel_r[4*k +: 4]];
      end
    end
  end

  // Pin input: the fast path skips only the last stage, never the synchroniser itself.
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
      pin_in_r <= 8'h00;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_in_r <= (s3_r & iocfg_r[IO_INS_LSB +: 8]) | (s2_r & ~iocfg_r[IO_INS_LSB +: 8]);
    end
  end

  assign oe_mode = ltscr_oe_t'(iocfg_r[IO_OEM_LSB +: 2]);

  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      unique case (oe_mode)
        OE_ALL: oe_c[i] = oe_rt[0];
        OE_QUAD: oe_c[i] = oe_rt[i / 4];
        OE_PAIR: oe_c[i] = oe_rt[i / 2];
        OE_SINGLE: oe_c[i] = (i < NUM_OE) ? oe_rt[i % NUM_OE] : oe_rt[NUM_OE-1];
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pipe_r <= 8'h00;
      pin_o_r <= 8'h00;
      pin_oe_n_r <= 8'hFF;
      drv_r <= 4'h0;
    end else begin
      pipe_r <= pin_out_rt;
      pin_o_r <= (pipe_r & iocfg_r[IO_OUTS_LSB +: 8]) | (pin_out_rt & ~iocfg_r[IO_OUTS_LSB +: 8]);
      pin_oe_n_r <= ~oe_c;
      drv_r <= drv_rt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign ctrl_rt = ctrl_rt_r;
  assign pta_clk_en = pta_en_r;
  assign req_out = req_r;
  assign dp_out = dp_out_r;
  assign chain_cout = chain_cout_r;
  assign chain_sout = chain_sout_r;
  assign chain_eq = chain_eq_r;
  assign pin_in_rt = pin_in_r;
  assign pin_drv = drv_r;
  assign pin_o = pin_o_r;
  assign pin_oe_n = pin_oe_n_r;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence bus_rq_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  ack_timing_a: assert property (bus_rq_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus answer is not a single cycle after the request.");
  ctrl_write_a: assert property (bus_rq_s ##0 (wb_we_i && adr_w == OFS_CTRL && wb_sel_i[0])
    |=> ctrl_r == $past(wb_dat_i[7:0]))
    else $error("Control register did not take the written value.");
  stat_set_a: assert property ((|stk_set) |=> (sticky_r & $past(stk_set)) == $past(stk_set))
    else $error("Status event lost.");
  stat_clr_a: assert property (stat_rd && stk_set == 8'h00 |=> sticky_r == 8'h00)
    else $error("Status read did not clear the held bits.");
  carry_reg_a: assert property (sub_en[SUB_DP] |=> carry_r == $past(alu_cout))
    else $error("Carry was not registered.");
  pin_sync_a: assert property (iocfg_r[IO_INS_LSB] [*5] |-> pin_in_rt[0] == $past(pin_i[0], 4))
    else $error("Synchronised pin input has wrong latency.");
  // The sampled reset keeps the edge that releases it from starting a check.
  oe_gang_a: assert property (!reset && oe_mode == OE_ALL
    |=> pin_oe_n == {PORT_W{!$past(oe_rt[0])}})
    else $error("Ganged output enable mismatch.");
  req_route_a: assert property (1'b1 |=> req_out[0] == $past(req_pick0))
    else $error("Request does not follow its selected signal.");
  clk_gate_a: assert property (clkcfg_r[CLK_GATE_BIT] && !ctrl_r[clkcfg_r[2:0]]
    |=> !pta_clk_en[0])
    else $error("Gated clock enable stayed on.");
endmodule
`default_nettype wire

/* File: rtl/ltscr_pkg.sv */
// Constants, field layouts and types of the logic tile status, control and routing block.
package ltscr_pkg;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int CTRL_W = 8;
  localparam int STAT_W = 8;
  localparam int RT_W = 8;
  localparam int ROUTE_W = 16;
  localparam int DP_IO = 6;
  localparam int NUM_REQ = 4;
  localparam int NUM_SUB = 4;
  localparam int PORT_W = 8;
  localparam int NUM_OE = 4;
  localparam int NUM_DRV = 4;
  localparam int CFG_AW = 3;
  localparam int CFG_W = 16;
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_STAT = 8'h04;
  localparam logic [ADR_W-1:0] OFS_STSEL = 8'h08;
  localparam logic [ADR_W-1:0] OFS_STKEN = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_CMAP = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CLKCFG = 8'h14;
  localparam logic [ADR_W-1:0] OFS_DPSEL = 8'h18;
  localparam logic [ADR_W-1:0] OFS_DPCTL = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_ACC = 8'h20;
  localparam logic [ADR_W-1:0] OFS_DATA = 8'h24;
  localparam logic [ADR_W-1:0] OFS_REQSEL = 8'h28;
  localparam logic [ADR_W-1:0] OFS_IOCFG = 8'h2C;
  localparam logic [ADR_W-1:0] OFS_CFGRAM = 8'h40;
  localparam int CW_OP_LSB = 0;
  localparam int CW_SH_LSB = 3;
  localparam int CW_CIN_LSB = 5;
  localparam int CW_SIN_LSB = 7;
  localparam int CW_WR_BIT = 9;
  localparam int CLK_GATE_BIT = 3;
  localparam int IO_INS_LSB = 0;
  localparam int IO_OUTS_LSB = 8;
  localparam int IO_OEM_LSB = 16;
  localparam int SUB_DP = 2;
  localparam int SUB_SC = 3;
  localparam logic [CTRL_W-1:0] RST_CTRL = 8'h00;
  localparam logic [31:0] RST_STSEL = 32'h76543210;
  localparam logic [23:0] RST_CMAP = 24'hFAC688;
  localparam logic [17:0] RST_IOCFG = 18'h000FF;
  typedef enum logic [2:0] {OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_PASS}
    ltscr_op_t;
  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} ltscr_sh_t;
  typedef enum logic [1:0] {CIN_ZERO, CIN_ONE, CIN_CHAIN, CIN_REG} ltscr_cin_t;
  typedef enum logic [1:0] {SIN_ROUTE, SIN_CHAIN, SIN_REG, SIN_ZERO} ltscr_sin_t;
  typedef enum logic [1:0] {OE_ALL, OE_QUAD, OE_PAIR, OE_SINGLE} ltscr_oe_t;
endpackage

/* File: rtl/ltscr_cfg_if.sv */
// Port between the tile logic and its dynamic configuration memory.
`timescale 1ns/1ps
`default_nettype none
interface ltscr_cfg_if #(parameter int AW = 3, parameter int DW = 16);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: rtl/ltscr_cfg_ram.sv */
// Dynamic datapath configuration memory with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module ltscr_cfg_ram #(
  parameter int AW = 3,
  parameter int DW = 16
) (
  // System
  input wire logic clk,
  input wire logic reset,
  // Memory port
  ltscr_cfg_if.mem mp
);
  logic [DW-1:0] mem_r [2**AW];
  logic [DW-1:0] rdata_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_r[i] <= '0;
      end
    end else if (mp.we) begin
      mem_r[mp.waddr] <= mp.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem_r[mp.raddr];
    end
  end

  assign mp.rdata = rdata_r;
endmodule
`default_nettype wire

/* File: dv/ltscr_route_model.sv */
// Routed peripheral logic that drives the tile's routing inputs.
`timescale 1ns/1ps
`default_nettype none
module ltscr_route_model
  import ltscr_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic reset,
  // Commands
  input wire logic [RT_W-1:0] lvl,
  input wire logic [RT_W-1:0] pulse,
  // Routing
  output logic [RT_W-1:0] rt_out
);
  logic [RT_W-1:0] lvl_r;
  logic [RT_W-1:0] pls_r;
  // A pulse command lasts one cycle, giving a transient event on the routing.
  always_ff @(posedge clk) begin
    if (reset) begin
      lvl_r <= 8'h00;
      pls_r <= 8'h00;
    end else begin
      lvl_r <= lvl;
      pls_r <= pulse;
    end
  end
  assign rt_out = lvl_r | pls_r;
endmodule
`default_nettype wire

/* File: dv/ltscr_tb_top.sv */
// Self-checking testbench of the logic tile status, control and routing block.
`timescale 1ns/1ps
`default_nettype none
module ltscr_tb_top
  import ltscr_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [ADR_W-1:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [DAT_W-1:0] wb_dat_w = 32'h0;
  logic [DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic [RT_W-1:0] rt_in;
  logic [RT_W-1:0] lvl = 8'h00;
  logic [RT_W-1:0] pulse = 8'h00;
  logic [CTRL_W-1:0] ctrl_rt;
  logic [1:0] pta_clk_en;
  logic [NUM_REQ-1:0] req_out;
  logic [DP_IO-1:0] dp_in = 6'h00;
  logic [DP_IO-1:0] dp_out;
  logic chain_cout;
  logic chain_ci = 1'b0;
  logic [PORT_W-1:0] pin_out_rt = 8'h00;
  logic [PORT_W-1:0] pin_i = 8'h00;
  logic [PORT_W-1:0] pin_in_rt;
  logic [PORT_W-1:0] pin_o;
  logic [PORT_W-1:0] pin_oe_n;
  logic [NUM_OE-1:0] oe_rt = 4'h5;
  logic [NUM_DRV-1:0] drv_rt = 4'h0;
  logic [NUM_DRV-1:0] pin_drv;
  logic [31:0] rd;
  logic [7:0] oe_exp [4] = '{8'h00, 8'hF0, 8'hCC, 8'hFA};
  int n_errors = 0;
  int total_checks = 0;
  int cyc_cnt = 0;

  always #10 clk = ~clk;

  ltscr_route_model u_ltscr_route_model (.clk(clk), .reset(reset), .lvl(lvl), .pulse(pulse),
    .rt_out(rt_in));

  // The carry from the neighbour is driven; its shift and compare inputs are tied off.
  ltscr_top u_ltscr_top (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rt_in(rt_in), .ctrl_rt(ctrl_rt),
    .pta_clk_en(pta_clk_en), .req_out(req_out), .dp_in(dp_in), .dp_out(dp_out),
    .chain_cin_i(chain_ci), .chain_sin_i(1'b0), .chain_eq_i(1'b0), .chain_cout(chain_cout),
    .chain_sout(), .chain_eq(), .pin_out_rt(pin_out_rt), .oe_rt(oe_rt), .drv_rt(drv_rt),
    .pin_in_rt(pin_in_rt), .pin_drv(pin_drv), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n));

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt > 5000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= 4'hF;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    chk("bus ack", 32'(wb_ack_o), 32'h1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
    chk("bus ack drop", 32'(wb_ack_o), 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  function automatic logic [7:0] probe(input int w);
    case (w)
      0: return pin_o;
      1: return pin_in_rt;
      default: return {4'h0, pin_drv};
    endcase
  endfunction

  // The value must still be old after n edges and new after n plus one.
  task automatic lat_chk(input string name, input int w, input int n, input logic [7:0] old,
    input logic [7:0] nw);
    repeat (n) @(posedge clk);
    chk(name, 32'(probe(w)), 32'(old));
    @(posedge clk);
    chk(name, 32'(probe(w)), 32'(nw));
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("pin_oe_n rst", 32'(pin_oe_n), 32'hFF);
    chk("pta_clk_en rst", 32'(pta_clk_en), 32'h3);
    chk("req_out rst", 32'(req_out), 32'h0);
    rd_chk("stsel rst", OFS_STSEL, 32'h76543210);
    rd_chk("cmap rst", OFS_CMAP, 32'h00FAC688);
    rd_chk("iocfg rst", OFS_IOCFG, 32'h000000FF);
    rd_chk("unmapped", 8'h3C, 32'h0);
    wr(OFS_CTRL, 32'h5A);
    chk("ctrl_rt", 32'(ctrl_rt), 32'h5A);
    rd_chk("ctrl", OFS_CTRL, 32'h5A);
    wr(OFS_CMAP, 32'h00FAC68F);
    wr(OFS_CTRL, 32'h80);
    chk("ctrl_rt map", 32'(ctrl_rt), 32'h81);
    wr(OFS_CLKCFG, 32'h0000000A);
    chk("clk gated", 32'(pta_clk_en), 32'h2);
    wr(OFS_CTRL, 32'h04);
    chk("clk enabled", 32'(pta_clk_en), 32'h3);
    wr(OFS_CLKCFG, 32'h0);
    // Status bits follow routing inputs 8 to 15, that is the routed signals.
    wr(OFS_STSEL, 32'hFEDCBA98);
    lvl <= 8'hA5;
    wr(OFS_STAT, 32'hFF);
    rd_chk("stat live", OFS_STAT, 32'hA5);
    lvl <= 8'h00;
    wr(OFS_STKEN, 32'hFF);
    pulse <= 8'h01;
    @(posedge clk);
    pulse <= 8'h00;
    repeat (4) @(posedge clk);
    rd_chk("stat held", OFS_STAT, 32'h01);
    rd_chk("stat cleared", OFS_STAT, 32'h00);
    lvl <= 8'h02;
    repeat (4) @(posedge clk);
    rd_chk("stat set", OFS_STAT, 32'h02);
    lvl <= 8'h00;
    repeat (4) @(posedge clk);
    rd_chk("stat set wins", OFS_STAT, 32'h02);
    rd_chk("stat after", OFS_STAT, 32'h00);
    wr(OFS_REQSEL, 32'h0000BA98);
    lvl <= 8'h05;
    repeat (4) @(posedge clk);
    chk("req_out", 32'(req_out), 32'h5);
    lvl <= 8'h0A;
    repeat (4) @(posedge clk);
    chk("req_out", 32'(req_out), 32'hA);
    // Words: add with carry one, registered carry, carry zero.
    wr(OFS_ACC, 32'hFF);
    wr(OFS_DATA, 32'h00);
    wr(OFS_CFGRAM, 32'h0022);
    wr(OFS_CFGRAM + 8'h04, 32'h0062);
    wr(OFS_CFGRAM + 8'h08, 32'h0002);
    rd_chk("cfg ram wo", OFS_CFGRAM, 32'h0);
    wr(OFS_DPSEL, 32'h194);
    wr(OFS_DPCTL, 32'h1);
    repeat (4) @(posedge clk);
    chk("dp word0", 32'(dp_out[2:0]), 32'h7);
    chk("chain cout", 32'(chain_cout), 32'h1);
    dp_in <= 6'h01;
    repeat (4) @(posedge clk);
    chk("dp word1", 32'(dp_out[2:0]), 32'h7);
    dp_in <= 6'h02;
    repeat (4) @(posedge clk);
    chk("dp word2", 32'(dp_out[2:0]), 32'h0);
    chk("chain cout", 32'(chain_cout), 32'h0);
    dp_in <= 6'h01;
    repeat (4) @(posedge clk);
    chk("dp carry reg", 32'(dp_out[2:0]), 32'h0);
    rd_chk("acc held", OFS_ACC, 32'hFF);
    // Word three takes its carry from the neighbour while chaining is on.
    wr(OFS_CFGRAM + 8'h0C, 32'h0042);
    chain_ci <= 1'b1;
    dp_in <= 6'h03;
    repeat (4) @(posedge clk);
    chk("dp chain cin", 32'(dp_out[0]), 32'h1);
    chain_ci <= 1'b0;
    repeat (4) @(posedge clk);
    chk("dp chain cin", 32'(dp_out[0]), 32'h0);
    // Word four subtracts and shifts left into the accumulator for one unheld cycle.
    wr(OFS_CFGRAM + 8'h10, 32'h03AB);
    dp_in <= 6'h24;
    repeat (3) @(posedge clk);
    dp_in <= 6'h04;
    @(posedge clk);
    dp_in <= 6'h24;
    rd_chk("acc sub shl", OFS_ACC, 32'hFE);
    wr(OFS_ACC, 32'hFF);
    wr(OFS_DPCTL, 32'h0);
    dp_in <= 6'h00;
    repeat (4) @(posedge clk);
    chk("chain off", 32'(chain_cout), 32'h0);
    pin_out_rt <= 8'h3C;
    lat_chk("pin_o", 0, 1, 8'h00, 8'h3C);
    pin_i <= 8'h5A;
    lat_chk("pin_in sync", 1, 4, 8'h00, 8'h5A);
    drv_rt <= 4'h9;
    lat_chk("pin_drv", 2, 1, 8'h00, 8'h09);
    wr(OFS_IOCFG, 32'h0000FF00);
    pin_out_rt <= 8'hC3;
    lat_chk("pin_o reg", 0, 2, 8'h3C, 8'hC3);
    pin_i <= 8'hA5;
    lat_chk("pin_in", 1, 3, 8'h5A, 8'hA5);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_IOCFG, {14'h0, 2'(m), 16'h00FF});
      chk("pin_oe_n", 32'(pin_oe_n), 32'(oe_exp[m]));
    end
    complete_run();
  end
endmodule
`default_nettype wire
